// file: vic_top.sv
/*
 * Vectored priority interrupt controller: apb register file, source
 * flags, external edge detection, trap flags, cpu priority level and
 * the vectored request toward the cpu core.
 * Assumes a single pclk domain; periph_irq and trap_event come from
 * logic on pclk, ext_irq_pin comes from pins.
 */
`timescale 1ns/10ps
`include "vic_consts.svh"

module vic_top (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // interrupt sources
    input wire logic [`VIC_NUM_SRC-1:0] periph_irq,
    input wire logic [2:0] ext_irq_pin,
    input wire logic [`VIC_NUM_TRAP-1:0] trap_event,
    // cpu core side
    output logic cpu_irq_req,
    output logic [23:0] cpu_irq_addr,
    output logic [3:0] cpu_irq_level,
    input wire logic cpu_irq_ack,
    input wire logic cpu_irq_return,
    input wire logic [3:0] cpu_return_level,
    output logic [3:0] cpu_level
);
    localparam logic [6:0] EXT_VEC [3] = '{`VIC_EXT0_VEC, `VIC_EXT1_VEC,
                                           `VIC_EXT2_VEC};

    vic_pkg::vic_src_vec_t flag;
    vic_pkg::vic_src_vec_t enable;
    logic [15:0] prio_reg [`VIC_NUM_PRIO_REG];
    logic nesting_disable;
    logic [`VIC_NUM_TRAP-1:0] trap_flag;
    logic alt_table_select;
    logic [2:0] ext_edge_polarity;
    logic [2:0] cpu_priority_level;
    logic top_bit;
    vic_pkg::vic_vec_t test_vec;
    vic_pkg::vic_level_t test_level;
    logic [2:0] ext_meta;
    logic [2:0] ext_sync;
    logic [2:0] ext_last;
    vic_pkg::vic_src_vec_t src_set;
    logic req_is_trap;
    vic_pkg::vic_vec_t req_num;
    logic trap_hit;
    logic [1:0] trap_idx;
    logic wr_en;
    logic setup;
    logic [32:0] rd_word;
    vic_arb_if arb ();

    // vector address: traps from the trap base, users from the user base
    function automatic vic_pkg::vic_addr_t vec_addr(input logic is_trap,
                                                    input logic [6:0] num,
                                                    input logic alt);
        vic_pkg::vic_addr_t a;
        if (is_trap)
            a = `VIC_TRAP_BASE + {16'h0000, num, 1'b0};
        else
            a = `VIC_USER_BASE + {16'h0000, num, 1'b0};
        if (alt)
            a = a + `VIC_ALT_OFFSET;
        return a;
    endfunction

    // trap level: lower trap vector means higher level, always above 7
    function automatic vic_pkg::vic_level_t trap_level(input logic [1:0] i);
        return 4'hf - {2'b00, i};
    endfunction

    // register read decode, shared by read data and error response
    function automatic logic [32:0] rd_decode(input logic [11:0] a);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        unique case (a)
            `VIC_OFS_CTRL1: r = {1'b1, 16'h0000, nesting_disable, 10'h000,
                                 trap_flag, 1'b0};
            `VIC_OFS_CTRL2: r = {1'b1, 16'h0000, alt_table_select, 12'h000,
                                 ext_edge_polarity};
            `VIC_OFS_STATUS: r = {1'b1, 24'h000000, cpu_priority_level, 5'h00};
            `VIC_OFS_CORE: r = {1'b1, 28'h0000000, top_bit, 3'h0};
            `VIC_OFS_TEST: r = {1'b1, 20'h00000, test_level, 1'b0,
                                test_vec};
            default: begin
                for (int g = 0; g < `VIC_NUM_GRP; g++) begin
                    if (a == `VIC_OFS_FLAG0 + 12'(4 * g))
                        r = {1'b1, 16'h0000, flag[g*16 +: 16]};
                    if (a == `VIC_OFS_EN0 + 12'(4 * g))
                        r = {1'b1, 16'h0000, enable[g*16 +: 16]};
                end
                for (int k = 0; k < `VIC_NUM_PRIO_REG; k++) begin
                    if (a == `VIC_OFS_PRIO0 + 12'(4 * k) &&
                        k != 13 && k != 14 && k != 17)
                        r = {1'b1, 16'h0000, prio_reg[k]};
                end
            end
        endcase
        return r;
    endfunction

    // decode in a process so register reads inside the function are seen
    always_comb begin
        rd_word = rd_decode(paddr);
    end

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    // apb answer one cycle after setup, so pready comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_word[31:0];
                pslverr <= !rd_word[32];
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // external pins: two-flop synchroniser, then a third flop for edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta <= 3'h0;
            ext_sync <= 3'h0;
            ext_last <= 3'h0;
        end else begin
            ext_meta <= ext_irq_pin;
            ext_sync <= ext_meta;
            ext_last <= ext_sync;
        end
    end

    // per-source set term: peripheral pulse or qualified pin edge
    always_comb begin
        src_set = periph_irq;
        for (int e = 0; e < 3; e++) begin
            if (ext_edge_polarity[e] ? (ext_last[e] && !ext_sync[e])
                                     : (!ext_last[e] && ext_sync[e]))
                src_set[EXT_VEC[e]] = 1'b1;
        end
    end

    // flag and enable groups, bit n of the flat vector is vector n
    generate
        for (genvar g = 0; g < `VIC_NUM_GRP; g++) begin : grp
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag[g*16 +: 16] <= 16'h0000;
                end else if (wr_en &&
                             paddr == `VIC_OFS_FLAG0 + 12'(4 * g)) begin
                    // a hardware set in the clearing cycle is kept
                    flag[g*16 +: 16] <= pwdata[15:0] |
                                        src_set[g*16 +: 16];
                end else begin
                    flag[g*16 +: 16] <= flag[g*16 +: 16] |
                                        src_set[g*16 +: 16];
                end
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    enable[g*16 +: 16] <= 16'h0000;
                else if (wr_en && paddr == `VIC_OFS_EN0 + 12'(4 * g))
                    enable[g*16 +: 16] <= pwdata[15:0];
            end
        end
    endgenerate

    // priority registers; the three absent ones stay zero, so their
    // sources sit at level 0 and can never interrupt
    generate
        for (genvar k = 0; k < `VIC_NUM_PRIO_REG; k++) begin : prg
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    prio_reg[k] <= 16'h0000;
                else if (wr_en && paddr == `VIC_OFS_PRIO0 + 12'(4 * k) &&
                         k != 13 && k != 14 && k != 17)
                    prio_reg[k] <= pwdata[15:0] & `VIC_PRIO_MASK;
            end
        end
    endgenerate

    // control one and two
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nesting_disable <= 1'b0;
            alt_table_select <= 1'b0;
            ext_edge_polarity <= 3'h0;
        end else if (wr_en) begin
            if (paddr == `VIC_OFS_CTRL1)
                nesting_disable <= pwdata[`VIC_CTRL1_NEST_BIT];
            if (paddr == `VIC_OFS_CTRL2) begin
                alt_table_select <= pwdata[`VIC_CTRL2_ALT_BIT];
                ext_edge_polarity <= pwdata[2:0];
            end
        end
    end

    // trap status flags: set by the trap source, cleared by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            trap_flag <= '0;
        else if (wr_en && paddr == `VIC_OFS_CTRL1)
            trap_flag <= pwdata[`VIC_CTRL1_TRAP_LSB +: `VIC_NUM_TRAP] |
                         trap_event;
        else
            trap_flag <= trap_flag | trap_event;
    end

    // resolver hookup; enable gates each request before resolution
    assign arb.pending = flag & enable;
    assign arb.cpu_level = {top_bit, cpu_priority_level};
    generate
        for (genvar s = 0; s < `VIC_NUM_SRC; s++) begin : pmap
            assign arb.prio[s] = prio_reg[s/4][(s%4)*4 +: 3];
        end
    endgenerate

    vic_resolver u_resolver (
        .bus(arb.arb)
    );

    // lowest numbered pending trap above the current level
    always_comb begin
        trap_hit = 1'b0;
        trap_idx = 2'h0;
        for (int t = `VIC_NUM_TRAP - 1; t >= 0; t--) begin
            if (trap_flag[t] && trap_level(2'(t)) > {top_bit, cpu_priority_level}) begin
                trap_hit = 1'b1;
                trap_idx = 2'(t);
            end
        end
    end

    // traps outrank every user level, so they take the request first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_irq_req <= 1'b0;
            cpu_irq_addr <= `VIC_RESET_ADDR;
            cpu_irq_level <= `VIC_LEVEL_RESET;
            req_is_trap <= 1'b0;
            req_num <= 7'h00;
        end else begin
            // drop for one cycle after an ack so the new level settles
            cpu_irq_req <= !cpu_irq_ack && (trap_hit || arb.win_valid);
            if (trap_hit) begin
                req_is_trap <= 1'b1;
                req_num <= {5'h00, trap_idx} + 7'h01;
                cpu_irq_addr <= vec_addr(1'b1, {5'h00, trap_idx} + 7'h01,
                                         alt_table_select);
                cpu_irq_level <= trap_level(trap_idx);
            end else begin
                req_is_trap <= 1'b0;
                req_num <= arb.win_vec;
                cpu_irq_addr <= vec_addr(1'b0, arb.win_vec,
                                         alt_table_select);
                cpu_irq_level <= {1'b0, arb.win_prio};
            end
        end
    end

    // cpu level: ack takes precedence over return, which beats software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_priority_level <= 3'h0;
            top_bit <= 1'b0;
        end else if (cpu_irq_ack && cpu_irq_req) begin
            top_bit <= cpu_irq_level[3];
            if (nesting_disable && !req_is_trap)
                cpu_priority_level <= `VIC_IPL_MAX;
            else
                cpu_priority_level <= cpu_irq_level[2:0];
        end else if (cpu_irq_return) begin
            {top_bit, cpu_priority_level} <= cpu_return_level;
        end else if (wr_en && paddr == `VIC_OFS_STATUS &&
                     !nesting_disable) begin
            cpu_priority_level <= pwdata[`VIC_STATUS_IPL_LSB +: 3];
        end
        // the core register has no write path for the top bit
    end

    // test register: trap vectors 0-7, user vector n reads as n+8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            test_vec <= 7'h00;
            test_level <= `VIC_LEVEL_RESET;
        end else if (cpu_irq_ack && cpu_irq_req) begin
            test_vec <= req_is_trap ? req_num
                                    : req_num + `VIC_USER_VECNUM_OFS;
            test_level <= cpu_irq_level;
        end
    end

    // level shown to the core through one more flop, a cycle behind its flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cpu_level <= `VIC_LEVEL_RESET;
        else
            cpu_level <= arb.cpu_level;
    end
endmodule

// file: vic_consts.svh
/*
 * Register offsets, field positions, reset values and vector figures for
 * the vectored priority interrupt controller.
 * Assumes inclusion by bare name from the package and the design files.
 */
// Summary of operation
// - alternate table select redirects every vector fetch
// - alternate entries sit 0x100 above default
// - device reset bypasses controller, execution starts 000000h
// - eight trap vectors at 000004h to 000012h
// - source bits ordered by vector number
// - 3-bit priority fields, four per register
// - flags set by source, cleared by software
// - enable bit gates request into resolution
// - each user source takes one of eight levels
// - software writes cpu priority bits 7:5
// - fourth priority bit is read-only
// - vector and new level latched on request
// - control one holds nesting disable, trap flags
// - control two holds polarity and table select
// - five flag, five enable, priority regs 0-20; the code leaves out regs 13, 14 and 17
// - equal priority, lower vector address wins
// - nesting disable blocks nesting, freezes cpu bits
// - polarity one falling edge, zero rising edge
// - cpu level seven disables all user interrupts
`ifndef VIC_CONSTS_SVH
`define VIC_CONSTS_SVH

`define VIC_NUM_SRC 80
`define VIC_NUM_GRP 5
`define VIC_NUM_PRIO_REG 21
`define VIC_NUM_TRAP 4

// apb word offsets
`define VIC_OFS_CTRL1 12'h000
`define VIC_OFS_CTRL2 12'h004
`define VIC_OFS_STATUS 12'h008
`define VIC_OFS_CORE 12'h00c
`define VIC_OFS_TEST 12'h010
`define VIC_OFS_FLAG0 12'h020
`define VIC_OFS_EN0 12'h040
`define VIC_OFS_PRIO0 12'h100

// field positions
`define VIC_CTRL1_NEST_BIT 15
`define VIC_CTRL1_TRAP_LSB 1
`define VIC_CTRL2_ALT_BIT 15
`define VIC_STATUS_IPL_LSB 5
`define VIC_CORE_TOP_BIT 3
`define VIC_TEST_LEVEL_LSB 8
`define VIC_PRIO_MASK 16'h7777

// vector map
`define VIC_RESET_ADDR 24'h000000
`define VIC_TRAP_BASE 24'h000004
`define VIC_USER_BASE 24'h000014
`define VIC_ALT_OFFSET 24'h000100
`define VIC_USER_VECNUM_OFS 7'h08
`define VIC_EXT0_VEC 7'h00
`define VIC_EXT1_VEC 7'h14
`define VIC_EXT2_VEC 7'h1d
`define VIC_LEVEL_RESET 4'h0
`define VIC_IPL_MAX 3'h7

`endif

// file: vic_pkg.sv
/*
 * Shared types of the interrupt controller.
 * Assumes vic_consts.svh on the include path.
 */
`include "vic_consts.svh"

package vic_pkg;
    typedef logic [2:0] vic_prio_t;
    typedef logic [3:0] vic_level_t;
    typedef logic [6:0] vic_vec_t;
    typedef logic [23:0] vic_addr_t;
    typedef logic [`VIC_NUM_SRC-1:0] vic_src_vec_t;
endpackage

// file: vic_arb_if.sv
/*
 * Carrier between the controller top and its priority resolver.
 * Assumes the resolver is purely combinational.
 */
`timescale 1ns/10ps
`include "vic_consts.svh"

interface vic_arb_if;
    vic_pkg::vic_src_vec_t pending;
    vic_pkg::vic_prio_t prio [`VIC_NUM_SRC];
    vic_pkg::vic_level_t cpu_level;
    logic win_valid;
    vic_pkg::vic_vec_t win_vec;
    vic_pkg::vic_prio_t win_prio;

    modport ctl (output pending, output prio, output cpu_level,
                 input win_valid, input win_vec, input win_prio);
    modport arb (input pending, input prio, input cpu_level,
                 output win_valid, output win_vec, output win_prio);
endinterface

// file: vic_resolver.sv
/*
 * Combinational priority resolver for the user interrupt sources.
 * Assumes pending already carries the enable gating.
 */
`timescale 1ns/10ps
`include "vic_consts.svh"

module vic_resolver (
    // request side and result
    vic_arb_if.arb bus
);
    // highest level wins; ascending scan with strict compare keeps the
    // lowest vector on ties, which matches table order
    always_comb begin
        bus.win_valid = 1'b0;
        bus.win_vec = 7'h00;
        bus.win_prio = 3'h0;
        for (int i = 0; i < `VIC_NUM_SRC; i++) begin
            if (bus.pending[i] &&
                {1'b0, bus.prio[i]} > bus.cpu_level &&
                (!bus.win_valid || bus.prio[i] > bus.win_prio)) begin
                bus.win_valid = 1'b1;
                bus.win_vec = 7'(i);
                bus.win_prio = bus.prio[i];
            end
        end
    end
endmodule

// file: vic_checker.sv
/*
 * Concurrent checks on the ports of the interrupt controller top.
 * Assumes a single pclk domain; bound onto vic_top at the foot.
 */
`timescale 1ns/10ps

module vic_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // cpu core side
    input wire logic cpu_irq_req,
    input wire logic [23:0] cpu_irq_addr,
    input wire logic [3:0] cpu_irq_level,
    input wire logic cpu_irq_ack,
    input wire logic [3:0] cpu_level
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // register access: zero wait states, one-cycle answer
    chk_apb_answer: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    chk_ready_once: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    // request stands until the core takes it
    chk_req_held: assert property (cpu_irq_req && !cpu_irq_ack |=> cpu_irq_req)
        else $error("request dropped before ack");
    chk_req_drop: assert property (cpu_irq_req && cpu_irq_ack |=> !cpu_irq_req)
        else $error("request kept after ack");
    // trap levels 15..12 map to trap vectors 1..4
    chk_trap_addr: assert property (cpu_irq_req && cpu_irq_level >= 4'hc |->
        cpu_irq_addr[7:0] == 8'h24 - {cpu_irq_level, 1'b0})
        else $error("trap address wrong");
    // user vectors lie in either table, word aligned
    chk_user_addr: assert property (cpu_irq_req && cpu_irq_level < 4'h8 |->
        cpu_irq_addr[7:0] >= 8'h14 && cpu_irq_addr[23:9] == 15'h0000 &&
        !cpu_irq_addr[0])
        else $error("user address out of table");
    chk_user_prio: assert property (cpu_irq_req && cpu_irq_level < 4'h8 |->
        cpu_irq_level != 4'h0)
        else $error("priority zero requested");
    // settled level seven masks every user source
    chk_level_seven: assert property ((cpu_level == 4'h7)[*3] |->
        !(cpu_irq_req && cpu_irq_level < 4'h8))
        else $error("user request at level seven");
    chk_reset_idle: assert property ($rose(presetn) |-> !cpu_irq_req &&
        cpu_irq_addr == 24'h000000 && cpu_level == 4'h0)
        else $error("outputs not idle after reset");

    cov_alt_ack: cover property (cpu_irq_req && cpu_irq_ack && cpu_irq_addr[8]);
    cov_trap_ack: cover property (cpu_irq_ack && cpu_irq_level == 4'hf);
    cov_slv_err: cover property (pslverr);
endmodule

bind vic_top vic_checker i_vic_checker (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .cpu_irq_req, .cpu_irq_addr, .cpu_irq_level,
    .cpu_irq_ack, .cpu_level);

// file: vic_cpu_model.sv
/*
 * Behavioural cpu core facing the controller: takes a request, runs a
 * handler for HOLD cycles, then returns to the level it left.
 * Assumes the controller holds its request until acknowledged.
 */
`timescale 1ns/10ps

module vic_cpu_model #(
    parameter int HOLD = 40
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the controller
    input wire logic cpu_irq_req,
    input wire logic [3:0] cpu_level,
    input wire logic slow,
    // answers to the controller
    output logic cpu_irq_ack,
    output logic cpu_irq_return,
    output logic [3:0] cpu_return_level
);
    int dly;
    int busy;

    // one handler at a time; slow mode waits a few cycles before taking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_irq_ack <= 1'b0;
            cpu_irq_return <= 1'b0;
            cpu_return_level <= 4'h0;
            dly <= 0;
            busy <= 0;
        end else begin
            cpu_irq_ack <= 1'b0;
            cpu_irq_return <= 1'b0;
            if (busy > 1) begin
                busy <= busy - 1;
            end else if (busy == 1) begin
                // handler never fetches unused entries; those would hold
                // the reset handler set up by software
                cpu_irq_return <= 1'b1; // restores the saved level
                busy <= 0;
            end else if (cpu_irq_req && !cpu_irq_ack) begin
                if (dly < (slow ? 3 : 0)) begin
                    dly <= dly + 1;
                end else begin
                    cpu_irq_ack <= 1'b1;
                    cpu_return_level <= cpu_level;
                    busy <= HOLD;
                    dly <= 0;
                end
            end
        end
    end
endmodule

// file: vic_top_bench.sv
/*
 * Self-checking bench for the interrupt controller: apb master, source
 * drivers, cpu model and an ack monitor.
 * Assumes vic_top, vic_cpu_model and vic_checker compiled before it.
 */
`timescale 1ns/10ps
`include "vic_consts.svh"

module vic_top_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [79:0] periph_irq;
    logic [2:0] ext_irq_pin;
    logic [3:0] trap_event, cpu_irq_level, cpu_return_level, cpu_level;
    logic cpu_irq_req, cpu_irq_ack, cpu_irq_return, slow, e, alt;
    logic [23:0] cpu_irq_addr, ack_addr;
    logic [3:0] ack_lvl;
    int n_errors = 0;
    int checks = 0;
    int n_ack = 0;
    int seed = 32'hdd03;
    int i, n, p, base;

    vic_top i_vic_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .periph_irq, .ext_irq_pin,
        .trap_event, .cpu_irq_req, .cpu_irq_addr, .cpu_irq_level,
        .cpu_irq_ack, .cpu_irq_return, .cpu_return_level, .cpu_level);
    vic_cpu_model #(.HOLD(40)) i_vic_cpu_model (.pclk, .presetn,
        .cpu_irq_req, .cpu_level, .slow, .cpu_irq_ack, .cpu_irq_return,
        .cpu_return_level);

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // capture what the core accepted
    always @(posedge pclk) begin
        if (cpu_irq_req === 1'b1 && cpu_irq_ack === 1'b1) begin
            n_ack <= n_ack + 1;
            ack_addr <= cpu_irq_addr;
            ack_lvl <= cpu_irq_level;
        end
    end

    task automatic results;
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // a hung wait counts as a mismatch and ends the run
    task automatic tmo;
        n_errors++;
        results();
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) tmo();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input string nm, input logic [11:0] a,
                      input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(nm, q, x);
    endtask

    task automatic wait_ack(input logic [23:0] xa, input logic [3:0] xl);
        int k;
        base = n_ack;
        for (k = 0; k < 40 && n_ack == base; k++) @(posedge pclk);
        if (n_ack == base) tmo();
        chk("ack_addr", {8'h00, ack_addr}, {8'h00, xa});
        chk("ack_level", {28'h0, ack_lvl}, {28'h0, xl});
    endtask

    task automatic wait_ret;
        int k;
        for (k = 0; k < 80 && cpu_irq_return !== 1'b1; k++) @(posedge pclk);
        if (k == 80) tmo();
    endtask

    task automatic kick(input logic [79:0] m);
        @(posedge pclk);
        periph_irq <= m;
        @(posedge pclk);
        periph_irq <= 80'h0;
    endtask

    task automatic src(input int v, input int pr);
        wr(12'(`VIC_OFS_EN0 + 4 * (v / 16)), 32'h1 << (v % 16));
        wr(12'(`VIC_OFS_PRIO0 + 4 * (v / 4)), pr << (4 * (v % 4)));
    endtask

    task automatic done(input int v);
        wr(12'(`VIC_OFS_FLAG0 + 4 * (v / 16)), 32'h0);
        wr(12'(`VIC_OFS_EN0 + 4 * (v / 16)), 32'h0);
        wait_ret();
    endtask

    function automatic logic [23:0] exp_addr(input int v, input logic a);
        return (a ? 24'h114 : 24'h014) + 24'(2 * v);
    endfunction

    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {periph_irq, ext_irq_pin, trap_event, slow} = '0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 5; i++) rd("reset", 12'(4 * i), 32'h0);
        rd("unmapped", 12'h134, 32'h0);
        chk("slverr", {31'h0, e}, 32'h1);
        wr(`VIC_OFS_PRIO0, 32'hffffffff);
        rd("prio_mask", `VIC_OFS_PRIO0, 32'h7777);
        for (i = 0; i < 12; i++) begin
            n = $unsigned($random(seed)) % 80;
            if (n == 20 || n == 29 || n / 4 inside {13, 14, 17}) n = 79;
            p = 1 + $unsigned($random(seed)) % 7;
            alt = $random(seed);
            slow <= $random(seed);
            wr(`VIC_OFS_CTRL2, {16'h0, alt, 15'h0});
            src(n, p);
            kick(80'h1 << n);
            wait_ack(exp_addr(n, alt), 4'(p));
            rd("flag", 12'(`VIC_OFS_FLAG0 + 4 * (n / 16)), 1 << (n % 16));
            rd("test", `VIC_OFS_TEST, (p << 8) | (n + 8));
            done(n);
        end
        wr(`VIC_OFS_CTRL2, 32'h0);
        wr(`VIC_OFS_PRIO0, 32'h0050);
        kick(80'h2);
        repeat (10) @(posedge pclk);
        chk("masked", n_ack, base + 1);
        rd("flag_kept", `VIC_OFS_FLAG0, 32'h2);
        wr(`VIC_OFS_EN0, 32'h2);
        wait_ack(24'h16, 4'h5);
        done(1);
        // equal priority: lower vector first, then the other
        wr(`VIC_OFS_EN0, 32'h0220);
        wr(`VIC_OFS_PRIO0 + 12'h4, 32'h0030);
        wr(`VIC_OFS_PRIO0 + 12'h8, 32'h0030);
        kick(80'h220);
        wait_ack(24'h1e, 4'h3);
        wr(`VIC_OFS_FLAG0, 32'h0200);
        wait_ret();
        wait_ack(24'h26, 4'h3);
        done(9);
        wr(`VIC_OFS_STATUS, 32'he0);
        rd("ipl", `VIC_OFS_STATUS, 32'he0);
        chk("cpu_level", {28'h0, cpu_level}, 32'h7);
        src(3, 7);
        kick(80'h8);
        repeat (10) @(posedge pclk);
        chk("blocked", n_ack, base + 1);
        wr(`VIC_OFS_STATUS, 32'h0);
        wait_ack(24'h1a, 4'h7);
        done(3);
        wr(`VIC_OFS_CTRL1, 32'h8000);
        wr(`VIC_OFS_STATUS, 32'h40);
        rd("ipl_frozen", `VIC_OFS_STATUS, 32'h0);
        src(3, 2);
        kick(80'h8);
        wait_ack(24'h1a, 4'h2);
        rd("no_nest", `VIC_OFS_STATUS, 32'he0);
        done(3);
        wr(`VIC_OFS_CTRL1, 32'h0);
        // each trap, alternating tables
        for (i = 0; i < 4; i++) begin
            alt = i[0];
            wr(`VIC_OFS_CTRL2, {16'h0, alt, 15'h0});
            @(posedge pclk);
            trap_event <= 4'h1 << i;
            @(posedge pclk);
            trap_event <= 4'h0;
            wait_ack(24'(alt ? 'h106 : 'h6) + 24'(2 * i), 4'(15 - i));
            rd("trap_flag", `VIC_OFS_CTRL1, 2 << i);
            wr(`VIC_OFS_CORE, 32'h0);
            rd("top_bit", `VIC_OFS_CORE, 32'h8);
            wr(`VIC_OFS_CTRL1, 32'h0);
            wait_ret();
        end
        wr(`VIC_OFS_CTRL2, 32'h0);
        src(0, 4);
        ext_irq_pin <= 3'b001;
        wait_ack(24'h14, 4'h4);
        ext_irq_pin <= 3'b000;
        done(0);
        wr(`VIC_OFS_CTRL2, 32'h2);
        src(20, 5);
        ext_irq_pin <= 3'b010;
        repeat (10) @(posedge pclk);
        chk("rise_ignored", n_ack, base + 1);
        ext_irq_pin <= 3'b000;
        wait_ack(24'h3c, 4'h5);
        done(20);
        results();
    end
endmodule
